/* File: dac_regs_map.svh */
// Register map constants for the converter status and output setup slice.
// Assumes inclusion by bare name from the register module.
`ifndef DAC_REGS_MAP_SVH
`define DAC_REGS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets on the serial configuration port
// ----------------------------------------------------------------------
`define ADDR_IRQ_ENABLE 7'h03
`define ADDR_IRQ_STATUS 7'h04
`define ADDR_CUR_LOW 7'h06
`define ADDR_CUR_HIGH 7'h07
`define ADDR_SWITCH_MODE 7'h08
`define ADDR_ALIGN_STATUS 7'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PHASE_LOST 3
`define BIT_PHASE_LOCKED 2
`define BIT_RX_LOST 1
`define BIT_RX_LOCKED 0
`define BIT_SLEEP 7
`define BIT_EDGE_EARLY 2
`define BIT_EDGE_LATE 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_IRQ_ENABLE 4'h0
`define RST_IRQ_STATUS 4'h0
`define RST_CUR_LOW 8'h00
`define RST_CUR_HIGH 2'h2
`define RST_SLEEP 1'b0
`define RST_ALIGN 2'h0

// ----------------------------------------------------------------------
// Serial frame shape: one instruction byte, one data byte
// ----------------------------------------------------------------------
`define SPI_LAST_BIT 3'h7

`endif

/* File: dac_regs_pkg.sv */
// Types shared by the status and output setup register slice.
// Uses no macros from the map header and does not include it.
`default_nettype none

package dac_regs_pkg;

   // Quad-switch output scheme, encoded 0, 1, 2 in this order.
   typedef enum logic [1:0] {
      MODE_BASEBAND,
      MODE_RETURN_TO_ZERO,
      MODE_MIX
   } switch_mode_t;

   // Controller status levels, laid out as the status register bits 3..0.
   typedef struct packed {
      logic phase_ctrl_lost;
      logic phase_ctrl_locked;
      logic rx_ctrl_lost;
      logic rx_ctrl_locked;
   } ctrl_stat_t;

   // Data clock edge comparison results against the delayed sampling edges.
   typedef struct packed {
      logic edge_before_early_phase0;
      logic edge_before_late_phase0;
   } edge_stat_t;

   // Output setup handed to the analog core.
   typedef struct packed {
      logic sleep;
      switch_mode_t output_switch_mode;
      logic [9:0] current_code;
   } dac_cfg_t;

   // Serial port frame states.
   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_INSTR,
      SPI_DATA,
      SPI_DONE
   } spi_state_t;

endpackage

`default_nettype wire

/* File: pin_sync3.sv */
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes an active-low asynchronous reset already released synchronously.
`default_nettype none

module pin_sync3 #(
   parameter int WIDTH = 9
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output var logic [WIDTH-1:0] q
);

   // ----------------------------------------------------------------------
   // Per-bit chain
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_r; // First stage, read only by the second.
      logic s2_r; // Second stage.
      logic s3_r; // Third stage.

      // Shift the pin through three flops; accept a change only when the
      // last two stages agree, which masks a single metastable sample.
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            s1_r <= d[i];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
               q[i] <= s3_r;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: dac_status_cfg_regs.sv */
// Status and output setup registers reached over the serial configuration port.
// Assumes serial clock, select and data pins arrive asynchronously to ref_clk.
`default_nettype none

`include "dac_regs_map.svh"

module dac_status_cfg_regs
   import dac_regs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdi,
   output var logic spi_sdo,
   output var logic spi_sdo_oe_n,
   input wire ctrl_stat_t ctrl_stat,
   input wire edge_stat_t edge_stat,
   output var dac_cfg_t dac_cfg
);

   // ----------------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------------
   logic rst_meta_r; // First reset release stage.
   logic rst_n; // Synchronously released reset used everywhere else.

   // Assert asynchronously, release after two clean clock edges.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------
   logic [8:0] pins_s; // Filtered copies of every asynchronous input.
   logic sclk_s; // Filtered serial clock.
   logic csb_n_s; // Filtered select, low during a frame.
   logic sdi_s; // Filtered serial data in.
   logic [3:0] ctrl_s; // Filtered controller status levels.
   logic [1:0] edge_s; // Filtered edge comparison results.

   // The select lane is carried inverted, so that the cleared reset value of
   // the synchroniser means no frame. Carried as is, the engine would see a
   // false frame start for a few cycles after reset.
   pin_sync3 #(.WIDTH(9)) u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d({spi_sclk, ~spi_csb_n, spi_sdi, ctrl_stat, edge_stat}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[8];
   assign csb_n_s = ~pins_s[7];
   assign sdi_s = pins_s[6];
   assign ctrl_s = pins_s[5:2];
   assign edge_s = pins_s[1:0];

   // ----------------------------------------------------------------------
   // Serial frame engine
   // ----------------------------------------------------------------------
   spi_state_t state_r; // Frame state.
   logic sclk_prev_r; // Serial clock one cycle back, for edge detection.
   logic [2:0] bit_cnt_r; // Bit index within the current byte.
   logic [7:0] shift_r; // Incoming bits.
   logic [7:0] instr_r; // Captured instruction: read flag and address.
   logic [7:0] out_r; // Outgoing read data; its top bit is the pin.
   logic sclk_rise; // Serial clock rising this cycle.
   logic sclk_fall; // Serial clock falling this cycle.
   logic [7:0] byte_in; // Byte completed by the current rising edge.
   logic instr_done; // Instruction byte completes this cycle.
   logic wr_commit; // Write data byte completes this cycle.
   logic [6:0] addr; // Address being decoded for a read.

   assign sclk_rise = sclk_s & ~sclk_prev_r;
   assign sclk_fall = ~sclk_s & sclk_prev_r;
   assign byte_in = {shift_r[6:0], sdi_s};
   assign instr_done = (state_r == SPI_INSTR) && sclk_rise && (bit_cnt_r == `SPI_LAST_BIT);
   assign wr_commit = (state_r == SPI_DATA) && sclk_rise && (bit_cnt_r == `SPI_LAST_BIT)
                      && !instr_r[7];
   assign addr = instr_done ? byte_in[6:0] : instr_r[6:0];

   // Track the frame: select low starts it, eight rising edges give the
   // instruction, eight more give or return the data byte, then the rest
   // of the frame is ignored until select rises.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= SPI_IDLE;
         sclk_prev_r <= 1'b0;
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         instr_r <= 8'h00;
      end else begin
         sclk_prev_r <= sclk_s;
         if (csb_n_s) begin
            // Select high aborts any frame in progress.
            state_r <= SPI_IDLE;
            bit_cnt_r <= 3'h0;
         end else begin
            case (state_r)
               SPI_IDLE: begin
                  state_r <= SPI_INSTR;
                  bit_cnt_r <= 3'h0;
               end
               SPI_INSTR, SPI_DATA: begin
                  if (sclk_rise) begin
                     shift_r <= byte_in;
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == `SPI_LAST_BIT) begin
                        state_r <= (state_r == SPI_INSTR) ? SPI_DATA : SPI_DONE;
                        if (state_r == SPI_INSTR) begin
                           instr_r <= byte_in;
                        end
                     end
                  end
               end
               default: begin
                  state_r <= SPI_DONE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [3:0] irq_en_r; // Write-only enables for the four status flags.
   logic [3:0] flags_r; // Controller status flags, bit order as read.
   logic [1:0] align_r; // Edge comparison status.

   // Enable register; a 0 later clears its flag.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= `RST_IRQ_ENABLE;
      end else if (wr_commit && instr_r[6:0] == `ADDR_IRQ_ENABLE) begin
         irq_en_r <= byte_in[3:0];
      end
   end

   // Each flag updates only while its enable is 1; a cleared enable forces
   // it to 0 and holds it there, so the clear beats any pending event.
   for (genvar i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            flags_r[i] <= 1'b0;
         end else if (!irq_en_r[i]) begin
            flags_r[i] <= 1'b0;
         end else if (i % 2 == 1) begin
            flags_r[i] <= flags_r[i] | ctrl_s[i];
         end else begin
            flags_r[i] <= ctrl_s[i];
         end
      end
   end

   // Edge order results are sampled continuously.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         align_r <= `RST_ALIGN;
      end else begin
         align_r <= edge_s;
      end
   end

   // Output setup; the code drives the current DAC linearly.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_cfg.current_code <= {`RST_CUR_HIGH, `RST_CUR_LOW};
         dac_cfg.sleep <= `RST_SLEEP;
         dac_cfg.output_switch_mode <= MODE_BASEBAND;
      end else if (wr_commit) begin
         if (instr_r[6:0] == `ADDR_CUR_LOW) begin
            dac_cfg.current_code[7:0] <= byte_in;
         end else if (instr_r[6:0] == `ADDR_CUR_HIGH) begin
            dac_cfg.current_code[9:8] <= byte_in[1:0];
            dac_cfg.sleep <= byte_in[`BIT_SLEEP];
         end else if (instr_r[6:0] == `ADDR_SWITCH_MODE) begin
            // The unused encoding 3 is refused; the mode stays as it was.
            if (byte_in[1:0] != 2'h3) begin
               dac_cfg.output_switch_mode <= switch_mode_t'(byte_in[1:0]);
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   logic [7:0] rd_data; // Read value of the addressed register.

   // Undefined bits and unmapped addresses read zero.
   always_comb begin
      rd_data = 8'h00;
      if (addr == `ADDR_IRQ_STATUS) begin
         rd_data[3:0] = flags_r;
      end else if (addr == `ADDR_CUR_LOW) begin
         rd_data = dac_cfg.current_code[7:0];
      end else if (addr == `ADDR_CUR_HIGH) begin
         rd_data[1:0] = dac_cfg.current_code[9:8];
         rd_data[`BIT_SLEEP] = dac_cfg.sleep;
      end else if (addr == `ADDR_SWITCH_MODE) begin
         rd_data[1:0] = dac_cfg.output_switch_mode;
      end else if (addr == `ADDR_ALIGN_STATUS) begin
         rd_data[`BIT_EDGE_EARLY] = align_r[1];
         rd_data[`BIT_EDGE_LATE] = align_r[0];
      end
   end

   // Load read data after the instruction, shift on each falling edge of the data byte but its first.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_r <= 8'h00;
         spi_sdo_oe_n <= 1'b1;
      end else begin
         if (instr_done) begin
            out_r <= byte_in[7] ? rd_data : 8'h00;
         end else if (sclk_fall && state_r == SPI_DATA && bit_cnt_r != 3'h0) begin
            out_r <= {out_r[6:0], 1'b0};
         end
         // Drive the data pin only during the data byte of a read.
         spi_sdo_oe_n <= !(state_r == SPI_DATA && instr_r[7] && !csb_n_s);
      end
   end

   assign spi_sdo = out_r[7];

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_locked_follow: assert property (
      irq_en_r[0] && $past(irq_en_r[0]) |-> flags_r[0] == $past(ctrl_s[0]))
      else $error("receiver locked flag does not follow its controller");

   chk_lost_sticky: assert property (
      flags_r[`BIT_PHASE_LOST] && irq_en_r[`BIT_PHASE_LOST] |=> flags_r[`BIT_PHASE_LOST])
      else $error("phase lost flag dropped while enabled");

   chk_status_read: assert property (
      instr_done && byte_in[7] && byte_in[6:0] == `ADDR_IRQ_STATUS
      |=> out_r == {4'h0, $past(flags_r)})
      else $error("status read returned wrong bits");

   chk_enable_clear: assert property (
      (flags_r & ~$past(irq_en_r)) == 4'h0)
      else $error("flag set while its enable was 0");

   chk_code_low: assert property (
      wr_commit && instr_r[6:0] == `ADDR_CUR_LOW
      |=> dac_cfg.current_code[7:0] == $past(byte_in))
      else $error("low current code not written");

   chk_high_sleep: assert property (
      wr_commit && instr_r[6:0] == `ADDR_CUR_HIGH
      |=> dac_cfg.current_code[9:8] == $past(byte_in[1:0])
          && dac_cfg.sleep == $past(byte_in[7]))
      else $error("high current code or sleep not written");

   chk_reset_code: assert property (
      $rose(rst_n) |-> dac_cfg.current_code == 10'h200 && !dac_cfg.sleep)
      else $error("current code reset value wrong");

   chk_mode_legal: assert property (
      dac_cfg.output_switch_mode != 2'h3)
      else $error("switch mode holds unused code");

   chk_align_follow: assert property (
      ##1 align_r == $past(edge_s))
      else $error("alignment status not tracking edges");

   chk_reserved_zero: assert property (
      instr_done && byte_in[7] && byte_in[6:0] == `ADDR_CUR_HIGH |=> out_r[6:2] == 5'h00)
      else $error("reserved bits read nonzero");

   cov_write: cover property (wr_commit);
   cov_read: cover property (instr_done && byte_in[7]);
   cov_lost: cover property ($rose(flags_r[`BIT_RX_LOST]));
   cov_mix: cover property (dac_cfg.output_switch_mode == MODE_MIX);

endmodule

`default_nettype wire

/* File: spi_host_model.sv */
// Host processor model that drives the serial configuration port.
// Assumes a free-running ref_clk; all pins change on its falling edge.
`default_nettype none

module spi_host_model (
   input wire logic ref_clk,
   output var logic spi_sclk,
   output var logic spi_csb_n,
   output var logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe_n,
   output var logic rd_valid,
   output var logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // Cycles per serial clock level, above the five that the port needs.
   localparam int HALF = 12;

   // ----------------------------------------
   // Idle pin levels
   // ----------------------------------------
   // The serial clock stands low and select high outside frames.
   initial begin
      spi_sclk = 1'b0;
      spi_csb_n = 1'b1;
      spi_sdi = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end

   // ----------------------------------------
   // One frame: instruction byte, then data byte
   // ----------------------------------------
   // Read data is taken just before each rising clock edge of the data
   // byte; an undriven output shows the inverse of its level, so a late
   // output enable shows up as a wrong bit.
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata);
      logic [15:0] frame;
      frame = {rd, addr, wdata};
      @(negedge ref_clk);
      spi_csb_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_sdi = frame[i];
         repeat (HALF) @(negedge ref_clk);
         if (i < 8) begin
            rd_data[i] = (spi_sdo_oe_n === 1'b0) ? spi_sdo : ~spi_sdo;
         end
         spi_sclk = 1'b1;
         repeat (HALF) @(negedge ref_clk);
         spi_sclk = 1'b0;
      end
      repeat (HALF) @(negedge ref_clk);
      spi_csb_n = 1'b1;
      // The data line is driven to the inverse level, so it no longer shows the last bit.
      spi_sdi = ~spi_sdi;
      rd_valid = rd;
      @(negedge ref_clk);
      rd_valid = 1'b0;
      repeat (HALF) @(negedge ref_clk);
   endtask
endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the status and output setup registers.
// Assumes the register package and the host model are compiled first.
`default_nettype none

module tb
   import dac_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic nrst;
   logic spi_sclk;
   logic spi_csb_n;
   logic spi_sdi;
   logic spi_sdo;
   logic spi_sdo_oe_n;
   logic rd_valid;
   logic [7:0] rd_data;
   ctrl_stat_t ctrl_stat;
   edge_stat_t edge_stat;
   dac_cfg_t dac_cfg;
   dac_cfg_t cfg_exp;
   logic [7:0] exp_q[$];
   logic [31:0] seed;
   int miscompares = 0;
   int num_checks = 0;

   // The 50 MHz clock.
   always #10 ref_clk = ~ref_clk;

   dac_status_cfg_regs dac_status_cfg_regs_inst (
      .ref_clk(ref_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
      .ctrl_stat(ctrl_stat), .edge_stat(edge_stat), .dac_cfg(dac_cfg)
   );

   spi_host_model spi_host_model_inst (
      .ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n), .spi_sdi(spi_sdi),
      .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .rd_valid(rd_valid),
      .rd_data(rd_data)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Xorshift step for repeatable random values.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Compares one read-back byte.
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compares the setup handed to the analog core.
   task automatic cmp_cfg(input dac_cfg_t got, input dac_cfg_t exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Notes the expected byte, then reads the register.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      spi_host_model_inst.xfer(1'b1, a, 8'h00);
   endtask

   // Writes one register.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      spi_host_model_inst.xfer(1'b0, a, d);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Takes the oldest note whenever the host finishes a read.
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp8(rd_data, 8'hxx);
         end else begin
            cmp8(rd_data, exp_q.pop_front());
         end
      end
   end

   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (50000) @(posedge ref_clk);
      miscompares++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      ctrl_stat = 4'h0;
      edge_stat = 2'h0;
      seed = 32'h0000805c;
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (20) @(negedge ref_clk);
      // Reset values.
      cfg_exp = {1'b0, MODE_BASEBAND, 10'h200};
      cmp_cfg(dac_cfg, cfg_exp);
      rd(7'h04, 8'h00);
      rd(7'h06, 8'h00);
      rd(7'h07, 8'h02);
      rd(7'h08, 8'h00);
      rd(7'h0c, 8'h00);
      // Current code, sleep and the unused bits between them.
      seed = xs(seed);
      wr(7'h06, seed[7:0]);
      wr(7'h07, 8'hfd);
      cfg_exp = {1'b1, MODE_BASEBAND, 2'b01, seed[7:0]};
      cmp_cfg(dac_cfg, cfg_exp);
      rd(7'h07, 8'h81);
      rd(7'h06, seed[7:0]);
      wr(7'h06, 8'hff);
      wr(7'h07, 8'h03);
      cfg_exp = {1'b0, MODE_BASEBAND, 10'h3ff};
      cmp_cfg(dac_cfg, cfg_exp);
      // Every mode, then the refused code 3.
      for (int m = 0; m < 4; m++) begin
         wr(7'h08, 8'(m));
         if (m < 3) begin
            cfg_exp.output_switch_mode = switch_mode_t'(m);
         end
         cmp_cfg(dac_cfg, cfg_exp);
         rd(7'h08, {6'h00, cfg_exp.output_switch_mode});
      end
      // Read-only, write-only and unmapped places.
      wr(7'h04, 8'hff);
      wr(7'h05, 8'hff);
      rd(7'h03, 8'h00);
      rd(7'h05, 8'h00);
      // Flags stay clear while their enables are off.
      @(negedge ref_clk);
      ctrl_stat = 4'hf;
      rd(7'h04, 8'h00);
      wr(7'h03, 8'h0f);
      rd(7'h04, 8'h0f);
      @(negedge ref_clk);
      ctrl_stat = 4'h0;
      rd(7'h04, 8'h0a);
      // Clearing and re-arming the enables, as software must.
      wr(7'h03, 8'h00);
      rd(7'h04, 8'h00);
      wr(7'h03, 8'h0f);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         @(negedge ref_clk);
         ctrl_stat = seed[3:0] & 4'h5;
         rd(7'h04, {4'h0, seed[3:0] & 4'h5});
      end
      @(negedge ref_clk);
      ctrl_stat = 4'h2;
      rd(7'h04, 8'h02);
      wr(7'h03, 8'h0d);
      rd(7'h04, 8'h00);
      // Data clock edge comparison results.
      for (int e = 0; e < 4; e++) begin
         @(negedge ref_clk);
         edge_stat = 2'(e);
         rd(7'h0c, {5'h00, e[1], 1'b0, e[0]});
      end
      tally_and_finish();
   end
endmodule

`default_nettype wire
